// ===== hw/srx_reset_ctl.sv
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
`include "srx_defs.svh"
module srx_reset_ctl #(
  parameter int NUM_IRQ = 24,
  parameter int WDG_BITS = 6,
  parameter int STAB_CYC = `SRX_STAB_CYC,
  parameter int PIN_LONG_CYC = `SRX_PIN_LONG_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic power_on_pulse,
  input wire logic low_voltage_in,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  input wire logic test_high_voltage,
  input wire logic break_state,
  input wire logic cpu_opcode_fetch,
  input wire logic cpu_illegal_opcode,
  input wire logic cpu_stop_instr,
  input wire logic cpu_addr_mapped,
  input wire logic cpu_bus_write,
  input wire logic [15:0] cpu_bus_addr,
  input wire logic cpu_instr_done,
  input wire logic cpu_mask_bit,
  input wire logic cpu_irq_ack,
  input wire logic stop_wake,
  input wire logic [NUM_IRQ-1:0] irq_req,
  output logic internal_reset,
  output logic clock_gen_output,
  output logic bus_clk_en,
  output logic [15:0] reset_vector,
  output logic irq_pending,
  output logic [15:0] irq_vector,
  output logic watchdog_tick,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  localparam int DRIVE_CYC = `SRX_DRIVE_CYC;
  localparam int HOLD_CYC = `SRX_HOLD_CYC;
  localparam int REL_CYC = `SRX_RELEASE_CYC;
  localparam int PIN_CYC = `SRX_PIN_CYC;
  srx_pkg::srx_state_e state;
  logic [12:0] prescale;
  logic [12:0] prescale_q;
  logic [12:0] seq_cnt;
  logic [12:0] pin_cnt;
  logic [WDG_BITS-1:0] wdg_cnt;
  logic [2:0] pin_sync;
  logic [2:0] lv_sync;
  logic pin_low;
  logic lv_level;
  logic long_seq;
  logic [7:0] cause;
  logic [7:0] ctrl;
  logic [NUM_IRQ-1:0] irq_en;
  logic [NUM_IRQ-1:0] irq_lat;
  logic irq_locked;
  logic [4:0] irq_sel;
  logic wdg_disable;
  logic wdg_svc;
  logic wdg_ovf;
  logic illegal_opcode_flag_ev;
  logic illegal_address_flag_ev;
  logic int_src;
  logic pre_ovf;
  logic [4:0] next_irq_sel;
  logic next_irq_any;

  function automatic logic [4:0] top_irq(input logic [NUM_IRQ-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      if (v[i])
      begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Pin and level synchronisers
  always_ff @(posedge ref_clk)
  begin
    pin_sync <= {pin_sync[1:0], rst_pin_in};
    lv_sync <= {lv_sync[1:0], low_voltage_in};
    if (sys_rst)
    begin
      pin_low <= 1'b0;
      lv_level <= 1'b0;
    end
    else
    begin
      if (pin_sync[1] == pin_sync[2])
      begin
        pin_low <= ~pin_sync[2];
      end
      if (lv_sync[1] == lv_sync[2])
      begin
        lv_level <= lv_sync[2];
      end
    end
  end

  assign wdg_disable = test_high_voltage & (ctrl[`SRX_CTL_MON] | break_state);
  assign wdg_svc = cpu_bus_write & (cpu_bus_addr == `SRX_WDG_SVC) & ~internal_reset;
  assign illegal_opcode_flag_ev = ~internal_reset & (cpu_illegal_opcode |
                   (cpu_stop_instr & ~ctrl[`SRX_CTL_STOPEN]));
  assign illegal_address_flag_ev = ~internal_reset & cpu_opcode_fetch & ~cpu_addr_mapped;
  assign wdg_ovf = watchdog_tick & (&wdg_cnt) & ~wdg_disable & ~internal_reset;
  assign int_src = wdg_ovf | illegal_opcode_flag_ev | illegal_address_flag_ev;
  assign pre_ovf = (prescale_q == 13'h1FFF) & (prescale == 13'h0000);

  always_ff @(negedge ref_clk)
  begin
    if (sys_rst)
    begin
      prescale <= 13'h0000;
    end
    else if (state == srx_pkg::SRX_STAB || state == srx_pkg::SRX_DRIVE ||
             (cpu_stop_instr & ctrl[`SRX_CTL_STOPEN] & state == srx_pkg::SRX_RUN))
    begin
      prescale <= 13'h0000;
    end
    else if (wdg_svc)
    begin
      prescale <= {9'h000, prescale[3:0] + 4'h1};
    end
    else if (state != srx_pkg::SRX_STOPPED)
    begin
      prescale <= prescale + 13'h0001;
    end
  end

  // Watchdog counter clocked by prescaler overflow
  always_ff @(posedge ref_clk)
  begin
    prescale_q <= prescale;
    if (sys_rst || internal_reset || wdg_svc)
    begin
      wdg_cnt <= '0;
      watchdog_tick <= 1'b0;
    end
    else
    begin
      watchdog_tick <= pre_ovf;
      if (watchdog_tick && !wdg_disable)
      begin
        wdg_cnt <= wdg_cnt + 1'b1;
      end
    end
  end

  // Reset sequencer
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || power_on_pulse)
    begin
      state <= srx_pkg::SRX_STAB;
      seq_cnt <= 13'h0000;
      long_seq <= 1'b1;
    end
    else
    begin
      seq_cnt <= seq_cnt + 13'h0001;
      case (state)
        srx_pkg::SRX_RUN:
        begin
          if (lv_level)
          begin
            state <= srx_pkg::SRX_STAB;
            seq_cnt <= 13'h0000;
            long_seq <= 1'b1;
          end
          else if (int_src)
          begin
            state <= srx_pkg::SRX_DRIVE;
            seq_cnt <= 13'h0000;
            long_seq <= 1'b0;
          end
          else if (pin_low)
          begin
            state <= srx_pkg::SRX_PINLOW;
            long_seq <= 1'b0;
          end
          else if (cpu_stop_instr && ctrl[`SRX_CTL_STOPEN])
          begin
            state <= srx_pkg::SRX_STOPPED;
          end
        end
        srx_pkg::SRX_STAB:
        begin
          if (seq_cnt == 13'(STAB_CYC - 1) && !lv_level)
          begin
            state <= srx_pkg::SRX_HOLD;
            seq_cnt <= 13'h0000;
          end
          else if (lv_level)
          begin
            seq_cnt <= 13'h0000;
          end
        end
        srx_pkg::SRX_DRIVE:
        begin
          if (seq_cnt == 13'(DRIVE_CYC - 1))
          begin
            state <= srx_pkg::SRX_HOLD;
            seq_cnt <= 13'h0000;
          end
        end
        srx_pkg::SRX_HOLD:
        begin
          if (seq_cnt == 13'((long_seq ? REL_CYC : HOLD_CYC) - 1) && !pin_low)
          begin
            state <= srx_pkg::SRX_RUN;
          end
        end
        srx_pkg::SRX_PINLOW:
        begin
          if (!pin_low)
          begin
            state <= srx_pkg::SRX_RUN;
          end
        end
        srx_pkg::SRX_STOPPED:
        begin
          if (stop_wake || pin_low)
          begin
            state <= srx_pkg::SRX_RECOVER;
            seq_cnt <= 13'h0000;
          end
        end
        srx_pkg::SRX_RECOVER:
        begin
          if (seq_cnt == 13'((ctrl[`SRX_CTL_SHORT_RECOVERY_BIT] ? `SRX_STOP_SHORT : `SRX_STOP_LONG) - 1))
          begin
            state <= srx_pkg::SRX_RUN;
          end
        end
        default:
        begin
          state <= srx_pkg::SRX_STAB;
        end
      endcase
    end
  end

  // Pin low counter
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !pin_low)
    begin
      pin_cnt <= 13'h0000;
    end
    else if (pin_cnt != 13'h1FFF)
    begin
      pin_cnt <= pin_cnt + 13'h0001;
    end
  end

  // Outputs
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rst_pin_out <= 1'b0;
      rst_pin_oe_n <= 1'b0;
      internal_reset <= 1'b1;
      clock_gen_output <= 1'b1;
      bus_clk_en <= 1'b0;
      reset_vector <= `SRX_RST_VEC;
    end
    else
    begin
      rst_pin_out <= 1'b0;
      rst_pin_oe_n <= ~(state == srx_pkg::SRX_STAB || state == srx_pkg::SRX_DRIVE);
      internal_reset <= (state != srx_pkg::SRX_RUN && state != srx_pkg::SRX_STOPPED &&
                         state != srx_pkg::SRX_RECOVER);
      reset_vector <= ctrl[`SRX_CTL_MON] ? `SRX_MON_VEC : `SRX_RST_VEC;
      clock_gen_output <= (state != srx_pkg::SRX_STOPPED);
      bus_clk_en <= (state == srx_pkg::SRX_RUN || state == srx_pkg::SRX_HOLD ||
                     state == srx_pkg::SRX_PINLOW);
    end
  end

  // Cause flags and configuration
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || power_on_pulse)
    begin
      cause <= 8'h80;
      ctrl <= `SRX_CTRL_RST;
      irq_en <= '0;
    end
    else
    begin
      if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0])
      begin
        if (wb_adr_i == `SRX_ADR_CTRL)
        begin
          ctrl <= wb_dat_i[7:0];
        end
        if (wb_adr_i == `SRX_ADR_IRQ)
        begin
          irq_en <= wb_dat_i[NUM_IRQ-1:0];
        end
      end
      if (state == srx_pkg::SRX_RUN && (lv_level || int_src || pin_low))
      begin
        cause <= 8'h00;
      end
      if (state == srx_pkg::SRX_RUN && lv_level)
      begin
        cause[`SRX_BIT_LVR] <= 1'b1;
      end
      if (wdg_ovf)
      begin
        cause[`SRX_BIT_WDG] <= 1'b1;
      end
      if (illegal_opcode_flag_ev)
      begin
        cause[`SRX_BIT_ILLEGAL_OPCODE_FLAG] <= 1'b1;
      end
      if (illegal_address_flag_ev)
      begin
        cause[`SRX_BIT_ILLEGAL_ADDRESS_FLAG] <= 1'b1;
      end
      if (pin_cnt == 13'(long_seq ? PIN_LONG_CYC : PIN_CYC))
      begin
        cause[`SRX_BIT_PIN] <= 1'b1;
      end
    end
  end

  // Interrupt latch and arbitration
  always_comb
  begin
    next_irq_sel = top_irq(irq_lat & irq_en);
    next_irq_any = |(irq_lat & irq_en);
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || internal_reset)
    begin
      irq_lat <= '0;
      irq_locked <= 1'b0;
      irq_sel <= 5'h00;
      irq_pending <= 1'b0;
      irq_vector <= `SRX_IRQ_VEC_TOP;
    end
    else
    begin
      // Set wins over acknowledge
      irq_lat <= (irq_lat & ~((cpu_irq_ack & irq_locked) ?
                 (NUM_IRQ'(1) << irq_sel) : '0)) | irq_req;
      if (cpu_irq_ack || cpu_mask_bit == 1'b0 && irq_locked && !irq_pending)
      begin
        irq_locked <= 1'b0;
        irq_pending <= 1'b0;
      end
      else if (!irq_locked && cpu_instr_done && !cpu_mask_bit && next_irq_any)
      begin
        irq_locked <= 1'b1;
        irq_sel <= next_irq_sel;
        irq_pending <= 1'b1;
        irq_vector <= `SRX_IRQ_VEC_TOP - {10'h000, next_irq_sel, 1'b0};
      end
    end
  end

  // Wishbone slave
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (wb_adr_i)
        `SRX_ADR_CAUSE: wb_dat_o <= {24'h000000, cause};
        `SRX_ADR_CTRL: wb_dat_o <= {24'h000000, ctrl};
        `SRX_ADR_IRQ: wb_dat_o <= 32'(irq_en);
        `SRX_ADR_STAT: wb_dat_o <= {22'h000000, state, irq_sel, irq_locked, internal_reset};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule // srx_reset_ctl

// ===== include/srx_defs.svh
`ifndef SRX_DEFS_SVH
`define SRX_DEFS_SVH
`define SRX_ADR_CAUSE 4'h0
`define SRX_ADR_CTRL 4'h4
`define SRX_ADR_IRQ 4'h8
`define SRX_ADR_STAT 4'hC
`define SRX_CTRL_RST 8'h00
`define SRX_BIT_POR 7
`define SRX_BIT_PIN 6
`define SRX_BIT_WDG 5
`define SRX_BIT_ILLEGAL_OPCODE_FLAG 4
`define SRX_BIT_ILLEGAL_ADDRESS_FLAG 3
`define SRX_BIT_LVR 1
`define SRX_CTL_STOPEN 0
`define SRX_CTL_SHORT_RECOVERY_BIT 1
`define SRX_CTL_MON 2
`define SRX_PIN_CYC 67
`define SRX_PIN_LONG_CYC 4163
`define SRX_DRIVE_CYC 32
`define SRX_HOLD_CYC 32
`define SRX_STAB_CYC 4096
`define SRX_RELEASE_CYC 64
`define SRX_STOP_SHORT 32
`define SRX_STOP_LONG 4096
`define SRX_RST_VEC 16'hFFFE
`define SRX_MON_VEC 16'hFEFE
`define SRX_WDG_SVC 16'hFFFF
`define SRX_SWI_VEC 16'hFFFC
`define SRX_IRQ_VEC_TOP 16'hFFFA
`endif

// ===== include/srx_pkg.sv
package srx_pkg;
  typedef enum logic [2:0] {
    SRX_RUN = 3'b000,
    SRX_STAB = 3'b001,
    SRX_DRIVE = 3'b011,
    SRX_HOLD = 3'b010,
    SRX_PINLOW = 3'b110,
    SRX_STOPPED = 3'b111,
    SRX_RECOVER = 3'b101
  } srx_state_e;
endpackage

// ===== sim/srx_far_model.sv
`timescale 1ns/1ps
module srx_far_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  input wire logic ext_low,
  input wire logic irq_pending,
  output logic rst_pin_in,
  output logic cpu_irq_ack
);
  logic [1:0] wait_cnt;
  assign rst_pin_in = ext_low ? 1'b0 : (rst_pin_oe_n ? 1'b1 : rst_pin_out);
  // Service a pending request after a short delay
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !irq_pending || cpu_irq_ack)
      wait_cnt <= 2'h0;
    else
      wait_cnt <= wait_cnt + 2'h1;
    cpu_irq_ack <= !sys_rst && irq_pending && !cpu_irq_ack && wait_cnt == 2'h3;
  end
endmodule // srx_far_model

// ===== sim/srx_reset_ctl_asserts.sv
`timescale 1ns/1ps
module srx_reset_ctl_asserts #(
  parameter int STAB_CYC = 4096
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cpu_illegal_opcode,
  input wire logic cpu_opcode_fetch,
  input wire logic cpu_addr_mapped,
  input wire logic cpu_irq_ack,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  input wire logic internal_reset,
  input wire logic clock_gen_output,
  input wire logic [15:0] reset_vector,
  input wire logic irq_pending,
  input wire logic [15:0] irq_vector
);
  logic [15:0] low_cnt;
  // Pin drive length
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || rst_pin_oe_n)
      low_cnt <= 16'h0000;
    else
      low_cnt <= low_cnt + 16'h0001;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  property p_pin_level;
    rst_pin_out == 1'b0;
  endproperty
  property p_drive_len;
    $rose(rst_pin_oe_n) |-> (low_cnt >= 16'h001F && low_cnt <= 16'h0022)
      || int'(low_cnt) >= STAB_CYC - 2;
  endproperty
  property p_hold_after;
    $rose(rst_pin_oe_n) |-> internal_reset [*8];
  endproperty
  property p_release;
    $rose(rst_pin_oe_n) |-> ##[28:70] !internal_reset;
  endproperty
  property p_clkgen;
    !rst_pin_oe_n |-> clock_gen_output;
  endproperty
  property p_vector;
    internal_reset |-> reset_vector == 16'hFFFE || reset_vector == 16'hFEFE;
  endproperty
  property p_illegal_opcode_flag;
    cpu_illegal_opcode && !internal_reset |-> ##[1:8] !rst_pin_oe_n;
  endproperty
  property p_illegal_address_flag;
    cpu_opcode_fetch && !cpu_addr_mapped && !internal_reset |-> ##[1:8] !rst_pin_oe_n;
  endproperty
  property p_latched;
    irq_pending && !cpu_irq_ack |=> irq_vector == $past(irq_vector);
  endproperty
  property p_reset_first;
    internal_reset [*2] |-> !irq_pending;
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin driven high");
  a_drive_len: assert property (p_drive_len) else $error("pin low length");
  a_hold_after: assert property (p_hold_after) else $error("reset hold short");
  a_release: assert property (p_release) else $error("no release");
  a_clkgen: assert property (p_clkgen) else $error("clock gen off");
  a_vector: assert property (p_vector) else $error("bad vector");
  a_illegal_opcode_flag: assert property (p_illegal_opcode_flag) else $error("no opcode reset");
  a_illegal_address_flag: assert property (p_illegal_address_flag) else $error("no address reset");
  a_latched: assert property (p_latched) else $error("preempted");
  a_reset_first: assert property (p_reset_first) else $error("irq in reset");
  c_irq: cover property ($rose(irq_pending));
  c_rel: cover property ($fell(internal_reset));
  c_pin: cover property ($rose(rst_pin_oe_n));
endmodule // srx_reset_ctl_asserts
bind srx_reset_ctl srx_reset_ctl_asserts #(.STAB_CYC(STAB_CYC)) u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .cpu_illegal_opcode(cpu_illegal_opcode),
  .cpu_opcode_fetch(cpu_opcode_fetch), .cpu_addr_mapped(cpu_addr_mapped),
  .cpu_irq_ack(cpu_irq_ack), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
  .internal_reset(internal_reset), .clock_gen_output(clock_gen_output),
  .reset_vector(reset_vector), .irq_pending(irq_pending), .irq_vector(irq_vector)
);

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk, sys_rst, power_on_pulse, low_voltage_in, rst_pin_in, rst_pin_out;
  logic rst_pin_oe_n, cpu_opcode_fetch, cpu_illegal_opcode, cpu_stop_instr, cpu_addr_mapped;
  logic cpu_instr_done, cpu_mask_bit, cpu_irq_ack, internal_reset, irq_pending, ext_low;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic cpu_bus_write, stop_wake, clock_gen_output, bus_clk_en, watchdog_tick;
  logic [15:0] reset_vector, irq_vector, cpu_bus_addr;
  logic [23:0] irq_req;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  srx_reset_ctl #(.STAB_CYC(64), .PIN_LONG_CYC(131), .WDG_BITS(1)) DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .power_on_pulse(power_on_pulse),
    .low_voltage_in(low_voltage_in), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe_n(rst_pin_oe_n), .test_high_voltage(1'b0), .break_state(1'b0),
    .cpu_opcode_fetch(cpu_opcode_fetch), .cpu_illegal_opcode(cpu_illegal_opcode),
    .cpu_stop_instr(cpu_stop_instr), .cpu_addr_mapped(cpu_addr_mapped),
    .cpu_bus_write(cpu_bus_write), .cpu_bus_addr(cpu_bus_addr),
    .cpu_instr_done(cpu_instr_done),
    .cpu_mask_bit(cpu_mask_bit), .cpu_irq_ack(cpu_irq_ack), .stop_wake(stop_wake),
    .irq_req(irq_req), .internal_reset(internal_reset),
    .clock_gen_output(clock_gen_output),
    .bus_clk_en(bus_clk_en), .reset_vector(reset_vector), .irq_pending(irq_pending),
    .irq_vector(irq_vector), .watchdog_tick(watchdog_tick), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
  );
  srx_far_model u_far (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .rst_pin_out(rst_pin_out),
    .rst_pin_oe_n(rst_pin_oe_n), .ext_low(ext_low), .irq_pending(irq_pending),
    .rst_pin_in(rst_pin_in), .cpu_irq_ack(cpu_irq_ack)
  );
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic complete_run;
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      errors = errors + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= we ? 4'h1 : 4'hF;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic settle(input logic [7:0] cause);
    repeat (8) @(posedge ref_clk);
    chk({16'h0000, reset_vector}, 32'h0000FFFE);
    do @(posedge ref_clk); while (internal_reset !== 1'b0);
    wb(1'b0, 4'h0, 32'h00000000);
    chk({24'h000000, rd[7:0]}, {24'h000000, cause});
  endtask
  task automatic t_illegal_opcode_flag;
    cpu_illegal_opcode <= 1'b1;
    cpu_opcode_fetch <= 1'b1;
    @(posedge ref_clk);
    cpu_illegal_opcode <= 1'b0;
    cpu_opcode_fetch <= 1'b0;
    settle(8'h10);
    cpu_stop_instr <= 1'b1;
    @(posedge ref_clk);
    cpu_stop_instr <= 1'b0;
    settle(8'h10);
  endtask
  task automatic t_illegal_address_flag;
    cpu_addr_mapped <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({31'h0, internal_reset}, 32'h00000000);
    cpu_opcode_fetch <= 1'b1;
    @(posedge ref_clk);
    cpu_opcode_fetch <= 1'b0;
    cpu_addr_mapped <= 1'b1;
    settle(8'h08);
  endtask
  task automatic t_src;
    ext_low <= 1'b1;
    repeat (80) @(posedge ref_clk);
    ext_low <= 1'b0;
    settle(8'h40);
    low_voltage_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
    low_voltage_in <= 1'b0;
    settle(8'h02);
    power_on_pulse <= 1'b1;
    @(posedge ref_clk);
    power_on_pulse <= 1'b0;
    settle(8'h80);
  endtask
  task automatic t_irq;
    wb(1'b1, 4'h8, 32'h00000028);
    cpu_instr_done <= 1'b1;
    irq_req <= 24'h0000A8;
    @(posedge ref_clk);
    irq_req <= 24'h000000;
    repeat (6) @(posedge ref_clk);
    chk({31'h0, irq_pending}, 32'h00000000);
    cpu_mask_bit <= 1'b0;
    do @(posedge ref_clk); while (irq_pending !== 1'b1);
    chk({16'h0000, irq_vector}, 32'h0000FFF0);
    do @(posedge ref_clk); while (cpu_irq_ack !== 1'b1);
    repeat (3) @(posedge ref_clk);
    do @(posedge ref_clk); while (irq_pending !== 1'b1);
    chk({16'h0000, irq_vector}, 32'h0000FFF4);
    do @(posedge ref_clk); while (cpu_irq_ack !== 1'b1);
    repeat (6) @(posedge ref_clk);
    chk({31'h0, irq_pending}, 32'h00000000);
  endtask
  task automatic t_stop;
    wb(1'b1, 4'h4, 32'h00000007);
    cpu_stop_instr <= 1'b1;
    @(posedge ref_clk);
    cpu_stop_instr <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({16'h0000, reset_vector}, 32'h0000FEFE);
    chk({30'h0, clock_gen_output, bus_clk_en}, 32'h00000000);
    stop_wake <= 1'b1;
    @(posedge ref_clk);
    stop_wake <= 1'b0;
    repeat (29) @(posedge ref_clk);
    chk({30'h0, clock_gen_output, bus_clk_en}, 32'h00000002);
    repeat (6) @(posedge ref_clk);
    chk({30'h0, clock_gen_output, bus_clk_en}, 32'h00000003);
    chk({31'h0, internal_reset}, 32'h00000000);
    wb(1'b1, 4'h4, 32'h00000000);
  endtask
  task automatic t_wdg;
    int n;
    n = 0;
    do @(posedge ref_clk); while (watchdog_tick !== 1'b1);
    cpu_bus_addr <= 16'hFFFF;
    cpu_bus_write <= 1'b1;
    @(posedge ref_clk);
    cpu_bus_write <= 1'b0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (watchdog_tick !== 1'b1);
    chk({31'h0, n >= 8170 && n <= 8200}, 32'h00000001);
    wb(1'b0, 4'h0, 32'h00000000);
    chk({24'h000000, rd[7:0]}, 32'h00000080);
    do @(posedge ref_clk); while (internal_reset !== 1'b1);
    settle(8'h20);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    {power_on_pulse, low_voltage_in, ext_low, cpu_opcode_fetch} = 4'h0;
    {cpu_illegal_opcode, cpu_stop_instr, cpu_instr_done, wb_cyc_i} = 4'h0;
    {wb_stb_i, wb_we_i, cpu_addr_mapped, cpu_mask_bit} = 4'h3;
    irq_req = 24'h000000;
    cpu_bus_write = 1'b0;
    stop_wake = 1'b0;
    cpu_bus_addr = 16'h0000;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h00000000;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    do @(posedge ref_clk); while (internal_reset !== 1'b0);
    wb(1'b0, 4'h0, 32'h00000000);
    chk(rd, 32'h00000080);
    t_illegal_opcode_flag();
    t_illegal_address_flag();
    t_src();
    t_irq();
    t_stop();
    t_wdg();
    complete_run();
  end
endmodule // testbench
